/* File: design/smc_top.sv */
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/1ps
module smc_top #(
    parameter int NPORT     = 8,
    parameter int CTRL_PORT = 0,
    parameter int MEM_WORDS = 32768
) (
    input  wire logic                     ref_clk,      // 40 MHz clock
    input  wire logic                     rst_b,        // Async reset, low
    input  wire logic [NPORT-1:0]         req_valid,    // Request held per port
    input  smc_pkg::smc_req_t [NPORT-1:0] req,          // Request fields
    input  wire logic [NPORT-1:0]         alt_valid,    // Altered word ready
    input  wire logic [31:0]              cell_set,     // Cell set pulses
    input  wire logic                     maint_load,   // Calendar load
    input  wire logic [51:0]              maint_val,    // Calendar load value
    input  wire logic [7:0]               reg_addr,     // Register address
    input  wire logic [31:0]              reg_wdata,    // Register write data
    input  wire logic                     reg_wr,       // Write strobe
    input  wire logic                     reg_rd,       // Read strobe
    output logic [31:0]                   reg_rdata,    // Read data
    output logic [NPORT-1:0]              done,         // Access done pulse
    output logic [NPORT-1:0]              alt_rdy,      // Alter data shown
    output logic [71:0]                   rdata,        // Read word(s)
    output logic [NPORT-1:0]              conn,         // Connect pulse
    output logic [35:0]                   conn_word,    // Connect operand
    output logic [NPORT-1:0]              ctl_int,      // Interrupt to ctl cpu
    output logic [4:0]                    ctl_cell      // Reported cell
);
    localparam int AW = $clog2(MEM_WORDS);
    localparam int CW = $clog2(smc_pkg::MEM_CYC);
    localparam int UW = $clog2(smc_pkg::US_CYC);
    localparam logic [CW-1:0] CYC_END = CW'(smc_pkg::MEM_CYC - 1);
    localparam logic [CW-1:0] ALT_END = CW'(smc_pkg::MEM_CYC - 3);
    localparam logic [UW-1:0] US_END  = UW'(smc_pkg::US_CYC - 1);

    // Lowest set bit index
    function automatic logic [4:0] first_set(input logic [31:0] v);
        logic [4:0] r;
        r = 5'h0;
        for (int i = 31; i >= 0; i--) begin
            if (v[i]) begin
                r = 5'(i);
            end
        end
        return r;
    endfunction : first_set

    // Stored word with odd parity bit on top
    function automatic logic [36:0] with_par(input logic [35:0] w);
        return {~^w, w};
    endfunction : with_par

    // Reset release
    logic rst_s1_q;
    logic rst_s2_q;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    wire rst_n = rst_s2_q;

    // Storage array, 36 data bits plus parity
    logic [36:0] mem [MEM_WORDS];

    smc_pkg::smc_state_t st_q;
    smc_pkg::smc_state_t st_d;
    logic [CW-1:0]       cyc_q;
    logic [2:0]          port_q;
    smc_pkg::smc_req_t   cur_q;
    logic [71:0]         rbuf_q;
    logic                par_err_q;
    logic                con_arm_q;

    // Fixed priority pick, port 0 first, done port skipped
    wire [31:0] req_vec = 32'(req_valid & ~done);
    wire        any_req = |req_vec;
    wire [4:0]  win_5   = first_set(req_vec);
    wire [2:0]  win     = win_5[2:0];

    // Pair and word addressing
    wire [AW-1:0] waddr = cur_q.addr[AW-1:0];
    wire [AW-1:0] even  = {waddr[AW-1:1], 1'b0};
    wire [AW-1:0] odd   = {waddr[AW-1:1], 1'b1};
    wire [35:0]   word_sel = waddr[0] ? rbuf_q[35:0] : rbuf_q[71:36];

    // Command decode
    wire c_rrs = cur_q.cmd == smc_pkg::CMD_RRS;
    wire c_rrd = cur_q.cmd == smc_pkg::CMD_RRD;
    wire c_cws = cur_q.cmd == smc_pkg::CMD_CWS;
    wire c_cwd = cur_q.cmd == smc_pkg::CMD_CWD;
    wire c_rar = cur_q.cmd == smc_pkg::CMD_RAR;
    wire c_chw = cur_q.cmd == smc_pkg::CMD_CHW;
    wire c_con = cur_q.cmd == smc_pkg::CMD_CON;
    wire c_wr  = c_cws | c_cwd | c_chw;

    // Character merge for partial word store
    wire [5:0]  sh6 = 6'(smc_pkg::CH6_TOP) - 6'(6 * cur_q.pos);
    wire [5:0]  sh9 = 6'(smc_pkg::CH9_TOP) - 6'(9 * cur_q.pos[1:0]);
    wire [35:0] ch_msk = cur_q.nine ? (smc_pkg::CH9_MSK << sh9)
                                    : (smc_pkg::CH6_MSK << sh6);
    wire [35:0] ch_dat = cur_q.nine ? (cur_q.wdata[35:0] << sh9)
                                    : (cur_q.wdata[35:0] << sh6);
    wire [35:0] merged = (word_sel & ~ch_msk) | (ch_dat & ch_msk);

    // Parity check on fetched pair
    wire [36:0] rd_e  = mem[even];
    wire [36:0] rd_o  = mem[odd];
    wire        p_bad = (rd_e != with_par(rd_e[35:0])) |
                        (rd_o != with_par(rd_o[35:0]));

    wire cyc_end = cyc_q == CYC_END;
    wire alt_in  = alt_valid[port_q];

    // Access sequencer, one memory cycle per request
    always_comb begin
        st_d = st_q;
        case (st_q)
            smc_pkg::ST_IDLE: begin
                if (any_req) begin
                    st_d = smc_pkg::ST_READ;
                end
            end
            smc_pkg::ST_READ: begin
                if (c_rar) begin
                    st_d = smc_pkg::ST_ALTER;
                end else if (c_wr) begin
                    st_d = smc_pkg::ST_WRITE;
                end else begin
                    st_d = smc_pkg::ST_DONE;
                end
            end
            smc_pkg::ST_ALTER: begin
                if (alt_in) begin
                    st_d = smc_pkg::ST_WRITE;
                end else if (cyc_q >= ALT_END) begin
                    st_d = smc_pkg::ST_DONE;
                end
            end
            smc_pkg::ST_WRITE: st_d = smc_pkg::ST_DONE;
            smc_pkg::ST_DONE: begin
                if (cyc_end) begin
                    st_d = smc_pkg::ST_IDLE;
                end
            end
            default: st_d = smc_pkg::ST_IDLE;
        endcase
    end

    // Sequencer state and cycle timer
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q  <= smc_pkg::ST_IDLE;
            cyc_q <= '0;
        end else begin
            st_q  <= st_d;
            cyc_q <= (st_q == smc_pkg::ST_IDLE) ? '0 : cyc_q + 1'b1;
        end
    end

    // Latch winning request; others wait until idle again
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            port_q <= 3'h0;
            cur_q  <= '0;
        end else if (st_q == smc_pkg::ST_IDLE && any_req) begin
            port_q <= win;
            cur_q  <= req[win];
        end else if (st_q == smc_pkg::ST_ALTER && alt_in) begin
            cur_q.wdata <= req[port_q].wdata;
        end
    end

    // Storage read and write
    always_ff @(posedge ref_clk) begin
        if (st_q == smc_pkg::ST_READ) begin
            rbuf_q <= {rd_e[35:0], rd_o[35:0]};
        end
        if (st_q == smc_pkg::ST_WRITE) begin
            if (c_cwd) begin
                mem[even] <= with_par(cur_q.wdata[71:36]);
                mem[odd]  <= with_par(cur_q.wdata[35:0]);
            end else if (c_chw) begin
                mem[waddr] <= with_par(merged);
            end else begin
                mem[waddr] <= with_par(cur_q.wdata[35:0]);
            end
        end
    end

    // Results back to requesters
    wire [NPORT-1:0] port_1h = NPORT'(1) << port_q;
    wire [NPORT-1:0] conn_1h = NPORT'(1) << conn_word[2:0];
    wire             rd_fin  = st_q == smc_pkg::ST_READ;
    wire             sh_rd   = rd_fin && (c_rrs || c_rar);
    wire [71:0]      rd_word = waddr[0] ? {36'h0, rd_o[35:0]}
                                        : {36'h0, rd_e[35:0]};
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            done      <= '0;
            alt_rdy   <= '0;
            rdata     <= '0;
            conn      <= '0;
            conn_word <= '0;
            par_err_q <= 1'b0;
        end else begin
            done    <= (st_q == smc_pkg::ST_DONE && cyc_end) ? port_1h : '0;
            alt_rdy <= (rd_fin && c_rar) ? port_1h : '0;
            if (sh_rd) begin
                rdata <= rd_word;
            end else if (rd_fin && c_rrd) begin
                rdata <= {rd_e[35:0], rd_o[35:0]};
            end
            conn <= con_arm_q ? conn_1h : '0;
            if (rd_fin && c_con) begin
                conn_word <= rd_word[35:0];
            end
            par_err_q <= par_err_q | (rd_fin && p_bad);
        end
    end

    // Connect needs the operand before the pulse
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            con_arm_q <= 1'b0;
        end else begin
            con_arm_q <= rd_fin && c_con;
        end
    end

    // Microsecond tick and calendar
    logic [UW-1:0] us_q;
    logic [51:0]   cal_q;
    wire           us_tick = us_q == US_END;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            us_q  <= '0;
            cal_q <= '0;
        end else begin
            us_q <= us_tick ? '0 : us_q + 1'b1;
            if (maint_load) begin
                cal_q <= maint_val;
            end else if (us_tick) begin
                cal_q <= cal_q + 1'b1;
            end
        end
    end

    // Alarm compare on the 64 microsecond bits
    localparam int AL = smc_pkg::ALARM_LSB;
    logic [51:AL] alarm_q;
    logic         match_q;
    wire          match = cal_q[51:AL] == alarm_q;
    wire          alarm_hit = match & ~match_q;

    // Register decode
    wire hit_mask  = reg_addr == smc_pkg::RG_MASK;
    wire hit_cells = reg_addr == smc_pkg::RG_CELLS;
    wire hit_callo = reg_addr == smc_pkg::RG_CALLO;
    wire hit_calhi = reg_addr == smc_pkg::RG_CALHI;
    wire hit_almlo = reg_addr == smc_pkg::RG_ALMLO;
    wire hit_almhi = reg_addr == smc_pkg::RG_ALMHI;
    wire hit_stat  = reg_addr == smc_pkg::RG_STAT;

    // Interrupt cells
    logic [31:0] cells_q;
    logic [31:0] mask_q;
    logic [19:0] calhi_q;
    wire  [31:0] alarm_vec = 32'(alarm_hit) << smc_pkg::ALARM_CELL;
    wire  [31:0] clr_vec   = (reg_wr && hit_cells) ? reg_wdata : 32'h0;
    wire  [31:0] sets      = cell_set | alarm_vec;
    wire  [31:0] live      = cells_q & ~mask_q;
    wire  [31:0] stat_word = {16'h0, 7'h0, par_err_q, 2'h0,
                              st_q != smc_pkg::ST_IDLE, ctl_cell};

    logic [31:0] rdo_q;
    assign reg_rdata = rdo_q;
    wire  [31:0] rd_mux = hit_mask  ? mask_q :
                          hit_cells ? cells_q :
                          hit_callo ? cal_q[31:0] :
                          hit_calhi ? {12'h0, calhi_q} :
                          hit_almlo ? {alarm_q[31:AL], {AL{1'b0}}} :
                          hit_almhi ? {12'h0, alarm_q[51:32]} :
                          hit_stat  ? stat_word : 32'h0;

    // Register file and interrupt report
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cells_q  <= '0;
            mask_q   <= smc_pkg::MASK_RST;
            alarm_q  <= '1;
            match_q  <= 1'b1;
            calhi_q  <= '0;
            rdo_q    <= '0;
            ctl_int  <= '0;
            ctl_cell <= '0;
        end else begin
            cells_q <= (cells_q & ~clr_vec) | sets;
            match_q <= match;
            if (reg_wr && hit_mask) begin
                mask_q <= reg_wdata;
            end
            if (reg_wr && hit_almlo) begin
                alarm_q[31:AL] <= reg_wdata[31:AL];
            end
            if (reg_wr && hit_almhi) begin
                alarm_q[51:32] <= reg_wdata[19:0];
            end
            if (reg_rd && hit_callo) begin
                calhi_q <= cal_q[51:32];
            end
            rdo_q    <= reg_rd ? rd_mux : 32'h0;
            ctl_int  <= (|live) ? (NPORT'(1) << CTRL_PORT) : '0;
            ctl_cell <= first_set(live);
        end
    end
endmodule : smc_top

/* File: include/smc_pkg.sv */
// Notes on behaviour
// - Up to eight requester ports; one fixed port is the control port.
// - Storage is 32k, 64k or 128k words of 36 bits plus parity.
// - Every memory access completes inside one microsecond memory cycle.
// - Reads and writes move one word or a word pair per command.
// - A single 6-bit or 9-bit character can be written, others untouched.
// - Requester gives command, address, data; controller stores or returns data.
// - Seven transfer commands; extended store never single-reads; only processors alter. The controller checks neither: any port may issue any command.
// - Read-alter-rewrite locks all other ports out until write-back.
// - Addressing granularity is the single word; pair commands use the even/odd word pair.
// - Connect forwards the operand word and a connect signal to its target.
// - Thirty-two interrupt cells, settable by any module or the clock.
// - A set cell signals the control processor with the cell number.
// - A 32-bit mask inhibits any combination of cells.
// - Calendar is a 52-bit counter ticking each microsecond, readable anytime.
// - No program path writes the calendar; only maintenance load does.
// - Writable alarm with 64 microsecond resolution compared continuously.
// - Calendar reaching the alarm sets an interrupt cell.
// - Simultaneous requests granted by fixed priority, port A highest.
package smc_pkg;
    localparam int W_DATA = 36;
    localparam int W_ADDR = 24;
    localparam int W_CAL  = 52;
    localparam int N_CELL = 32;
    localparam int CLK_PS = 25000;
    localparam int US_PS  = 1000000;
    localparam int MEM_CYC_PS = 1000000;
    localparam int US_CYC  = US_PS / CLK_PS;
    localparam int MEM_CYC = MEM_CYC_PS / CLK_PS;
    localparam int ALARM_LSB = 6;
    localparam int ALARM_CELL = 31;
    // Register byte offsets
    localparam logic [7:0] RG_MASK  = 8'h00;
    localparam logic [7:0] RG_CELLS = 8'h04;
    localparam logic [7:0] RG_CALLO = 8'h08;
    localparam logic [7:0] RG_CALHI = 8'h0c;
    localparam logic [7:0] RG_ALMLO = 8'h10;
    localparam logic [7:0] RG_ALMHI = 8'h14;
    localparam logic [7:0] RG_STAT  = 8'h18;
    localparam logic [31:0] MASK_RST = 32'hffff_ffff;
    // Transfer commands
    localparam logic [2:0] CMD_RRS = 3'h0;
    localparam logic [2:0] CMD_RRD = 3'h1;
    localparam logic [2:0] CMD_CWS = 3'h2;
    localparam logic [2:0] CMD_CWD = 3'h3;
    localparam logic [2:0] CMD_RAR = 3'h4;
    localparam logic [2:0] CMD_CHW = 3'h5;
    localparam logic [2:0] CMD_CON = 3'h6;
    // Character field shapes
    localparam logic [35:0] CH6_MSK = 36'h0_0000_003f;
    localparam logic [35:0] CH9_MSK = 36'h0_0000_01ff;
    localparam int CH6_TOP = 30;
    localparam int CH9_TOP = 27;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_READ  = 3'h1,
        ST_ALTER = 3'h3,
        ST_WRITE = 3'h2,
        ST_DONE  = 3'h6
    } smc_state_t;
    typedef struct packed {
        logic [2:0]        cmd;
        logic [W_ADDR-1:0] addr;
        logic [71:0]       wdata;
        logic              nine;
        logic [2:0]        pos;
    } smc_req_t;
endpackage : smc_pkg

/* File: sim/smc_top_assertions.sv */
`timescale 1ns/1ps
module smc_top_assertions #(
    parameter int NPORT     = 8,
    parameter int CTRL_PORT = 0
) (
    input wire logic             ref_clk,    // Clock
    input wire logic             rst_b,      // Async reset, low
    input wire logic [NPORT-1:0] req_valid,  // Port requests
    input wire logic             reg_wr,     // Write strobe
    input wire logic             reg_rd,     // Read strobe
    input wire logic [31:0]      reg_rdata,  // Read data
    input wire logic [NPORT-1:0] done,       // Access done
    input wire logic [NPORT-1:0] alt_rdy,    // Alter word shown
    input wire logic [NPORT-1:0] conn,       // Connect pulse
    input wire logic [35:0]      conn_word,  // Connect operand
    input wire logic [NPORT-1:0] ctl_int,    // Interrupt out
    input wire logic [4:0]       ctl_cell    // Reported cell
);
    // Port zero as a one-hot seed
    wire logic [NPORT-1:0] port_one = {{(NPORT-1){1'b0}}, 1'b1};
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // Access timing, ownership and exclusion
    done_onehot_a: assert property ($onehot0(done))
        else $error("done on several ports");
    done_latency_a: assert property (done != '0 |-> ($past(req_valid, 40) & req_valid & done) == done)
        else $error("done without a held request");
    done_gap_a: assert property (done != '0 |=> (done == '0) [*8])
        else $error("done pulses too close");
    alter_owner_a: assert property (alt_rdy != '0 |-> $onehot(alt_rdy) && (req_valid & alt_rdy) == alt_rdy)
        else $error("alter word shown to idle port");
    alter_done_a: assert property (alt_rdy != '0 |-> ##39 done == $past(alt_rdy, 39))
        else $error("alter not finished on time");
    // Connect forwarding
    conn_target_a: assert property (conn != '0 |-> conn == (port_one << conn_word[2:0]))
        else $error("connect sent to wrong port");
    conn_done_a: assert property (conn != '0 |-> ##38 done != '0)
        else $error("connect access not closed");
    // Interrupt reporting and register reads
    int_port_a: assert property (ctl_int == (ctl_int & (port_one << CTRL_PORT)))
        else $error("interrupt on non-control port");
    cell_idle_a: assert property (!ctl_int[CTRL_PORT] |-> ctl_cell == 5'h00)
        else $error("cell number without interrupt");
    cell_hold_a: assert property ($fell(ctl_int[CTRL_PORT]) |-> $past(reg_wr) || $past(reg_wr, 2) || $past(reg_wr, 3))
        else $error("interrupt dropped without software");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside read cycle");
    cover property (alt_rdy != '0);
    cover property (conn != '0);
    cover property ($rose(ctl_int[CTRL_PORT]));
endmodule : smc_top_assertions

bind smc_top smc_top_assertions #(.NPORT(NPORT), .CTRL_PORT(CTRL_PORT)) smc_top_assertions_i (
    .ref_clk(ref_clk), .rst_b(rst_b), .req_valid(req_valid), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .done(done), .alt_rdy(alt_rdy), .conn(conn), .conn_word(conn_word),
    .ctl_int(ctl_int), .ctl_cell(ctl_cell));

/* File: sim/smc_req_model.sv */
`timescale 1ns/1ps
module smc_req_model (
    input wire logic          ref_clk,   // Clock
    input wire logic          start,     // Launch a request
    input smc_pkg::smc_req_t  new_req,   // Request to present
    input wire logic [35:0]   alt_word,  // Word to write back
    input wire logic [7:0]    alt_wait,  // Alter answer delay
    input wire logic          done,      // Access done
    input wire logic          alt_rdy,   // Alter word shown
    output logic              req_valid, // Request held
    output smc_pkg::smc_req_t req,       // Request fields
    output logic              alt_valid  // Altered word pulse
);
    logic [7:0] wait_q;
    logic       alt_pend_q;
    initial begin
        req_valid = 1'b0;
        req = '0;
        alt_valid = 1'b0;
        alt_pend_q = 1'b0;
        wait_q = 8'h00;
    end
    // Hold request until done, scramble fields when idle
    always @(posedge ref_clk) begin
        alt_valid <= 1'b0;
        if (start) begin
            req_valid <= 1'b1; // absolute address, any command
            req <= new_req; // one controller, no interlace
        end else if (done) begin
            req_valid <= 1'b0;
        end else if (!req_valid) begin
            req <= ~req;
        end
        if (alt_rdy) begin
            alt_pend_q <= 1'b1;
            wait_q <= alt_wait;
        end else if (alt_pend_q && wait_q == 8'h00) begin
            alt_pend_q <= 1'b0;
            alt_valid <= 1'b1; // altered word back
            req.wdata[35:0] <= alt_word;
        end else if (alt_pend_q) begin
            wait_q <= wait_q - 8'h01;
        end
    end
endmodule : smc_req_model

/* File: sim/smc_tb_top.sv */
`timescale 1ns/1ps
module smc_tb_top;
    logic                         ref_clk = 1'b0;
    logic                         rst_b = 1'b0;
    logic [7:0]                   start = '0;
    smc_pkg::smc_req_t            nreq [8];
    logic [35:0]                  alt_word = '0;
    logic [7:0]                   alt_wait = '0;
    logic [31:0]                  cell_set = '0;
    logic                         maint_load = 1'b0;
    logic [51:0]                  maint_val = '0;
    logic [7:0]                   reg_addr = '0;
    logic [31:0]                  reg_wdata = '0;
    logic                         reg_wr = 1'b0;
    logic                         reg_rd = 1'b0;
    wire logic [7:0]              req_valid, alt_valid, done, alt_rdy, conn, ctl_int;
    wire smc_pkg::smc_req_t [7:0] req_bus;
    wire logic [31:0]             reg_rdata;
    wire logic [71:0]             rdata;
    wire logic [35:0]             conn_word;
    wire logic [4:0]              ctl_cell;
    int                           miscompares = 0;
    int                           comparisons = 0;
    logic [7:0]                   conn_seen, done_seen;
    logic [35:0]                  w, msk;
    logic [31:0]                  rv;
    int                           sh;
    always #12.5 ref_clk = ~ref_clk;
    // One requester model per port
    for (genvar g = 0; g < 8; g++) begin : g_port
        smc_req_model smc_req_model_i (.ref_clk(ref_clk), .start(start[g]), .new_req(nreq[g]), .alt_word(alt_word),
            .alt_wait(alt_wait), .done(done[g]), .alt_rdy(alt_rdy[g]), .req_valid(req_valid[g]), .req(req_bus[g]),
            .alt_valid(alt_valid[g]));
    end
    smc_top smc_top_i (.ref_clk(ref_clk), .rst_b(rst_b), .req_valid(req_valid), .req(req_bus), .alt_valid(alt_valid),
        .cell_set(cell_set), .maint_load(maint_load), .maint_val(maint_val), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .done(done),
        .alt_rdy(alt_rdy), .rdata(rdata), .conn(conn), .conn_word(conn_word), .ctl_int(ctl_int), .ctl_cell(ctl_cell));
    // Comparison, verdict and bus tasks
    task automatic chk(input string what, input logic [71:0] exp, input logic [71:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic conclude;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask : reg_write
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : reg_read
    task automatic launch(input logic [7:0] m, input logic [2:0] c, input logic [23:0] a, input logic [71:0] d,
                          input logic nine = 1'b0, input logic [2:0] pos = 3'h0);
        @(posedge ref_clk);
        for (int p = 0; p < 8; p++) if (m[p]) nreq[p] <= '{cmd: c, addr: a, wdata: d, nine: nine, pos: pos};
        start <= m;
        @(posedge ref_clk);
        start <= '0;
    endtask : launch
    task automatic wait_done(input int p);
        int n;
        conn_seen = '0;
        done_seen = '0;
        for (n = 0; n < 100 && done[p] !== 1'b1; n++) begin
            @(posedge ref_clk);
            #1;
            conn_seen = conn_seen | conn;
            done_seen = done_seen | done;
        end
        if (n == 100) begin
            miscompares++;
            $display("CHECK FAILED done port %0d expected 1 seen 0", p);
            conclude();
        end
    endtask : wait_done
    task automatic access(input int p, input logic [2:0] c, input logic [23:0] a, input logic [71:0] d,
                          input logic nine = 1'b0, input logic [2:0] pos = 3'h0);
        launch(8'h01 << p, c, a, d, nine, pos);
        wait_done(p);
    endtask : access
    // Main sequence
    initial begin
        foreach (nreq[i]) nreq[i] = '0;
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge ref_clk);
        reg_read(smc_pkg::RG_MASK, rv);
        chk("mask reset", 72'(smc_pkg::MASK_RST), 72'(rv)); // mask
        reg_read(8'h1c, rv);
        chk("unmapped read", 72'h0, 72'(rv)); // empty place
        $display("test reset_values ended");
        access(2, smc_pkg::CMD_CWS, 24'h00000a, 72'h1_2345_6789); // store
        access(2, smc_pkg::CMD_RRS, 24'h00000a, '0); // fetch
        chk("single read", 72'h1_2345_6789, rdata); // one word
        access(3, smc_pkg::CMD_CWD, 24'h000014, {36'ha_bcde_f012, 36'h3_4567_89ab}); // pair
        access(3, smc_pkg::CMD_RRD, 24'h000015, '0); // odd address
        chk("pair read", {36'ha_bcde_f012, 36'h3_4567_89ab}, rdata); // pair
        access(3, smc_pkg::CMD_RRS, 24'h000015, '0); // odd word
        chk("odd word", 72'h3_4567_89ab, rdata); // odd word
        w = 36'h1_2345_6789;
        for (int k = 0; k < 2; k++) begin
            sh = (k == 0) ? 27 - 9 * 1 : 30 - 6 * 4;
            msk = (k == 0) ? 36'h1ff : 36'h03f;
            access(2, smc_pkg::CMD_CHW, 24'h00000a, 72'h0ab, k == 0, (k == 0) ? 3'h1 : 3'h4); // char
            w = (w & ~(msk << sh)) | ((36'h0ab & msk) << sh);
            access(2, smc_pkg::CMD_RRS, 24'h00000a, '0);
            chk("char write", {36'h0, w}, rdata); // others kept
        end
        for (int k = 0; k < 2; k++) begin
            alt_word <= w ^ 36'h00f;
            alt_wait <= (k == 0) ? 8'd20 : 8'd0;
            access(0, smc_pkg::CMD_RAR, 24'h00000a, '0); // alter
            w = w ^ 36'h00f;
            access(0, smc_pkg::CMD_RRS, 24'h00000a, '0);
            chk("alter result", {36'h0, w}, rdata); // written back
        end
        launch(8'h22, smc_pkg::CMD_CWS, 24'h00001e, 72'h5); // two at once
        wait_done(1);
        chk("grant order", 72'h02, 72'(done_seen));
        wait_done(5);
        access(4, smc_pkg::CMD_CWS, 24'h000028, 72'h3);
        access(0, smc_pkg::CMD_CON, 24'h000028, '0); // connect
        chk("connect target", 72'h08, 72'(conn_seen)); // target port
        chk("connect word", 72'h3, 72'(conn_word)); // operand
        $display("test storage ended");
        @(posedge ref_clk);
        cell_set <= 32'h0000_0210;
        @(posedge ref_clk);
        cell_set <= '0;
        reg_read(smc_pkg::RG_CELLS, rv);
        chk("cells set", 72'h210, 72'(rv)); // set by modules
        chk("masked int", 72'h0, 72'(ctl_int)); // inhibited
        reg_write(smc_pkg::RG_MASK, 32'h0);
        chk("int raised", 72'h01, 72'(ctl_int)); // control port
        chk("first cell", 72'h4, 72'(ctl_cell)); // lowest first
        reg_write(smc_pkg::RG_CELLS, 32'h10);
        chk("next cell", 72'h9, 72'(ctl_cell)); // still pending
        reg_write(smc_pkg::RG_CELLS, 32'h200);
        chk("int cleared", 72'h0, 72'(ctl_int)); // cleared
        $display("test interrupts ended");
        @(posedge ref_clk);
        maint_load <= 1'b1;
        maint_val <= 52'h0_0002_0000_0fc0;
        @(posedge ref_clk);
        maint_load <= 1'b0;
        reg_read(smc_pkg::RG_CALLO, rv);
        chk("calendar low", 72'h0fc0, 72'(rv & 32'hffff_fffe)); // readable
        reg_read(smc_pkg::RG_CALHI, rv);
        chk("calendar high", 72'h2, 72'(rv)); // upper bits
        reg_write(smc_pkg::RG_CALLO, 32'h0);
        reg_read(smc_pkg::RG_CALLO, rv);
        chk("calendar kept", 72'h0fc0, 72'(rv & 32'hffff_fffc));
        reg_write(smc_pkg::RG_ALMLO, 32'h0000_1000); // alarm
        reg_write(smc_pkg::RG_ALMHI, 32'h2); // alarm
        repeat (2400) @(posedge ref_clk);
        reg_read(smc_pkg::RG_CELLS, rv);
        chk("alarm early", 72'h0, 72'(rv));
        repeat (400) @(posedge ref_clk);
        reg_read(smc_pkg::RG_CELLS, rv);
        chk("alarm cell", 72'h8000_0000, 72'(rv)); // alarm sets cell
        chk("alarm reported", 72'd31, 72'(ctl_cell)); // reported
        $display("test calendar ended");
        conclude();
    end
endmodule : smc_tb_top
